// ---- logic/pmx_pkg.sv ----
// Constants and types for the port B sideband pin control block
package pmx_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] ADDR_BASIC_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    // Basic control, bit 0 upward: isolate, clk_dir, clk_strength,
    // manual_duplex, duplex_mode
    typedef struct packed {
        logic duplex_mode;
        logic manual_duplex;
        logic clk_strength;
        logic clk_dir;
        logic isolate;
    } pmx_ctrl_s;
    localparam int CTRL_W = 5;
    localparam pmx_ctrl_s CTRL_RESET = 5'h00;

    // Latched straps
    typedef struct packed {
        logic polarity;
        logic [2:0] mode;
    } pmx_strap_s;
    localparam int STRAP_W = 4;
    localparam pmx_strap_s STRAP_RESET = 4'h0;

    // Status field positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_DUPLEX_BIT = 3;
    localparam int STAT_COL_BIT = 4;
    localparam int STAT_CRS_BIT = 5;
    localparam int STAT_POL_BIT = 6;
    localparam int STAT_CAPT_BIT = 7;

    // ------------------------------------------------------------
    // Port mode strap encoding
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_MII_MAC = 3'h0;
    localparam logic [2:0] MODE_MII_PHY = 3'h1;
    localparam logic [2:0] MODE_TURBO_12 = 3'h2;
    localparam logic [2:0] MODE_TURBO_16 = 3'h3;
    localparam logic [2:0] MODE_RMII_OUT_12 = 3'h4;
    localparam logic [2:0] MODE_RMII_OUT_16 = 3'h5;
    localparam logic [2:0] MODE_RMII_IN = 3'h6;
    localparam logic [2:0] MODE_INT_PHY = 3'h7;

    // Strap capture sequencer
    typedef enum logic [2:0] {
        CAP_LOAD = 3'b001,
        CAP_RUN = 3'b010,
        CAP_HOLD = 3'b100
    } pmx_cap_e;

    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 100;
    localparam int RMII_REF_MHZ = 50;
    localparam int MII_REF_MHZ = 25;
    localparam int RMII_HALF_CYC = CLK_FREQ_MHZ / (2 * RMII_REF_MHZ);
    localparam int MII_HALF_CYC = CLK_FREQ_MHZ / (2 * MII_REF_MHZ);
    localparam int DIV_W = 4;

endpackage

// ---- logic/pmx_pin_ctrl.sv ----
// Port B reference clock, collision, carrier and duplex pin control
// Operation
// - In RMII PHY mode the reference clock pin carries a 50 MHz clock timing the data and valid lines.
// - In RMII PHY mode the reference clock pin is an input when clock direction is 0 and an output when 1.
// - As an input the reference clock pull-down is on, and isolate turns off both buffer and pull-down.
// - As an output the buffer and pull-down are off, strength picks 12 or 16 mA, and isolate kills the driver.
// - The collision pin is an input in MII MAC mode, a driven output in MII PHY mode unless isolated, unused in RMII.
// - The carrier pin is an input in MII MAC mode, a driven output in MII PHY mode unless isolated, unused in RMII.
// - In MII MAC mode the duplex pin is followed live unless manual duplex substitutes the register setting.
// - In MII PHY and RMII PHY modes the duplex pin only sets the duplex mode default and its pull-up stays on.
// - In internal PHY mode the reference clock, collision, carrier and duplex pins are unused.
// - Strap levels are captured at power-on reset and on each release of the external reset pin.
// - Latched strap values may be replaced by EEPROM loader values after capture.
// - The three-bit mode strap selects MII MAC, MII PHY, turbo MII PHY, RMII PHY out or in, or internal PHY.
// - The reference clock is an input in MII MAC mode and a driven output clock in MII PHY mode.
//
// Added by the designer: the register offsets and strobed register access.
module pmx_pin_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic [pmx_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pmx_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pmx_pkg::DATA_W-1:0] reg_rdata,
    input wire logic external_reset_pin_n,
    input wire logic [2:0] port_b_mode_strap,
    input wire logic port_b_duplex_polarity_strap,
    input wire logic eeprom_load,
    input wire logic [2:0] eeprom_mode,
    input wire logic eeprom_polarity,
    input wire logic core_collision,
    input wire logic core_carrier,
    output logic link_collision,
    output logic link_carrier,
    output logic link_full_duplex,
    output logic ref_clock_is_output,
    input wire logic port_b_ref_clock_pin_i,
    output logic port_b_ref_clock_pin_o,
    output logic port_b_ref_clock_pin_oe,
    output logic port_b_ref_clock_pin_drive_16ma,
    output logic port_b_ref_clock_pin_ibuf_en,
    output logic port_b_ref_clock_pin_pd_en,
    input wire logic port_b_collision_pin_i,
    output logic port_b_collision_pin_o,
    output logic port_b_collision_pin_oe,
    input wire logic port_b_carrier_pin_i,
    output logic port_b_carrier_pin_o,
    output logic port_b_carrier_pin_oe,
    input wire logic port_b_duplex_pin_i,
    output logic port_b_duplex_pin_pu_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Pin synchronisers (clk domain)
    // ------------------------------------------------------------
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] pin_raw;
    assign pin_raw = {external_reset_pin_n, port_b_mode_strap,
                      port_b_duplex_polarity_strap, port_b_collision_pin_i,
                      port_b_carrier_pin_i};
    logic dup_meta;
    logic dup_sync;

    always_ff @(posedge clk) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
        dup_meta <= port_b_duplex_pin_i;
        dup_sync <= dup_meta;
    end

    logic rst_pin_n;
    logic [2:0] strap_mode_pin;
    logic strap_pol_pin;
    logic col_in;
    logic crs_in;
    assign rst_pin_n = pin_sync[6];
    assign strap_mode_pin = pin_sync[5:3];
    assign strap_pol_pin = pin_sync[2];
    assign col_in = pin_sync[1];
    assign crs_in = pin_sync[0];

    // ------------------------------------------------------------
    // Strap capture and register state
    // ------------------------------------------------------------
    pmx_pkg::pmx_cap_e cap_state;
    pmx_pkg::pmx_cap_e next_cap_state;
    pmx_pkg::pmx_strap_s strap;
    pmx_pkg::pmx_strap_s next_strap;
    pmx_pkg::pmx_ctrl_s ctrl;
    pmx_pkg::pmx_ctrl_s next_ctrl;
    logic captured;
    logic next_captured;
    logic [pmx_pkg::DATA_W-1:0] next_reg_rdata;

    // Decoded mode classes
    logic m_mac;
    logic m_mii_phy;
    logic m_rmii;
    logic m_int;
    assign m_mac = (strap.mode == pmx_pkg::MODE_MII_MAC);
    assign m_mii_phy = (strap.mode == pmx_pkg::MODE_MII_PHY)
        || (strap.mode == pmx_pkg::MODE_TURBO_12)
        || (strap.mode == pmx_pkg::MODE_TURBO_16);
    assign m_rmii = (strap.mode == pmx_pkg::MODE_RMII_OUT_12)
        || (strap.mode == pmx_pkg::MODE_RMII_OUT_16)
        || (strap.mode == pmx_pkg::MODE_RMII_IN);
    assign m_int = (strap.mode == pmx_pkg::MODE_INT_PHY);

    // Polarity strap says which pin level means full duplex
    logic pin_full;
    logic duplex_eff;
    assign pin_full = ~(dup_sync ^ strap.polarity);
    assign duplex_eff = m_mac ? (ctrl.manual_duplex ? ctrl.duplex_mode
                                                    : pin_full)
                              : ctrl.duplex_mode;

    // Control defaults that follow the mode strap
    function automatic pmx_pkg::pmx_ctrl_s strap_defaults(
        input logic [2:0] mode,
        input logic dup_full
    );
        pmx_pkg::pmx_ctrl_s c;
        c = pmx_pkg::CTRL_RESET;
        case (mode)
            pmx_pkg::MODE_TURBO_16: c.clk_strength = 1'b1;
            pmx_pkg::MODE_RMII_OUT_12: c.clk_dir = 1'b1;
            pmx_pkg::MODE_RMII_OUT_16: begin
                c.clk_dir = 1'b1;
                c.clk_strength = 1'b1;
            end
            default: c.clk_dir = 1'b0;
        endcase
        c.duplex_mode = dup_full;
        return c;
    endfunction

    always_comb begin
        next_cap_state = cap_state;
        next_strap = strap;
        next_ctrl = ctrl;
        next_captured = captured;
        next_reg_rdata = '0;
        case (cap_state)
            pmx_pkg::CAP_LOAD: begin
                next_strap.mode = strap_mode_pin;
                next_strap.polarity = strap_pol_pin;
                next_ctrl = strap_defaults(strap_mode_pin,
                    ~(dup_sync ^ strap_pol_pin));
                next_captured = 1'b1;
                next_cap_state = pmx_pkg::CAP_RUN;
            end
            pmx_pkg::CAP_RUN: begin
                if (!rst_pin_n) begin
                    next_cap_state = pmx_pkg::CAP_HOLD;
                end else if (eeprom_load) begin
                    next_strap.mode = eeprom_mode;
                    next_strap.polarity = eeprom_polarity;
                    next_ctrl = strap_defaults(eeprom_mode,
                        ~(dup_sync ^ eeprom_polarity));
                end else if (reg_wr
                        && reg_addr == pmx_pkg::ADDR_BASIC_CONTROL) begin
                    next_ctrl = pmx_pkg::pmx_ctrl_s'(
                        reg_wdata[pmx_pkg::CTRL_W-1:0]);
                end
            end
            pmx_pkg::CAP_HOLD: begin
                // Strap and control registers stay frozen while the pin holds reset; captured clears
                next_captured = 1'b0;
                if (rst_pin_n) begin
                    next_cap_state = pmx_pkg::CAP_LOAD;
                end
            end
            default: next_cap_state = pmx_pkg::CAP_LOAD;
        endcase
        if (reg_rd) begin
            case (reg_addr)
                pmx_pkg::ADDR_BASIC_CONTROL:
                    next_reg_rdata[pmx_pkg::CTRL_W-1:0] = ctrl;
                pmx_pkg::ADDR_STATUS: begin
                    next_reg_rdata[pmx_pkg::STAT_MODE_LSB +: 3] = strap.mode;
                    next_reg_rdata[pmx_pkg::STAT_DUPLEX_BIT] = duplex_eff;
                    next_reg_rdata[pmx_pkg::STAT_COL_BIT] = col_in & m_mac;
                    next_reg_rdata[pmx_pkg::STAT_CRS_BIT] = crs_in & m_mac;
                    next_reg_rdata[pmx_pkg::STAT_POL_BIT] = strap.polarity;
                    next_reg_rdata[pmx_pkg::STAT_CAPT_BIT] = captured;
                end
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cap_state <= pmx_pkg::CAP_LOAD;
            strap <= pmx_pkg::STRAP_RESET;
            ctrl <= pmx_pkg::CTRL_RESET;
            captured <= 1'b0;
            reg_rdata <= '0;
        end else begin
            cap_state <= next_cap_state;
            strap <= next_strap;
            ctrl <= next_ctrl;
            captured <= next_captured;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Reference clock generation and pin roles
    // ------------------------------------------------------------
    logic [pmx_pkg::DIV_W-1:0] div_cnt;
    logic [pmx_pkg::DIV_W-1:0] next_div_cnt;
    logic [pmx_pkg::DIV_W-1:0] div_half;
    logic ref_out;
    logic next_ref_out;
    logic clk_out_mode;
    logic next_clk_oe;
    logic clk_oe;
    logic next_drive16;
    logic drive16;
    logic next_ibuf;
    logic ibuf;
    logic next_pd;
    logic pd;

    assign div_half = m_rmii ? pmx_pkg::DIV_W'(pmx_pkg::RMII_HALF_CYC)
                             : pmx_pkg::DIV_W'(pmx_pkg::MII_HALF_CYC);
    assign clk_out_mode = m_mii_phy || (m_rmii && ctrl.clk_dir);

    always_comb begin
        next_div_cnt = div_cnt + 1'b1;
        next_ref_out = ref_out;
        if (next_div_cnt >= div_half) begin
            next_div_cnt = '0;
            next_ref_out = ~ref_out;
        end
        next_clk_oe = clk_out_mode && !ctrl.isolate && !m_int;
        next_drive16 = clk_out_mode && ctrl.clk_strength;
        next_ibuf = !clk_out_mode && !m_int && !ctrl.isolate;
        next_pd = !clk_out_mode && !ctrl.isolate;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= '0;
            ref_out <= 1'b0;
            clk_oe <= 1'b0;
            drive16 <= 1'b0;
            ibuf <= 1'b0;
            pd <= 1'b1;
        end else begin
            div_cnt <= next_div_cnt;
            ref_out <= next_ref_out;
            clk_oe <= next_clk_oe;
            drive16 <= next_drive16;
            ibuf <= next_ibuf;
            pd <= next_pd;
        end
    end

    assign port_b_ref_clock_pin_o = ref_out;
    assign port_b_ref_clock_pin_oe = clk_oe;
    assign port_b_ref_clock_pin_drive_16ma = drive16;
    assign port_b_ref_clock_pin_ibuf_en = ibuf;
    assign port_b_ref_clock_pin_pd_en = pd;
    assign ref_clock_is_output = clk_out_mode;
    assign port_b_duplex_pin_pu_en = 1'b1;

    // ------------------------------------------------------------
    // Collision, carrier and duplex toward the core
    // ------------------------------------------------------------
    logic next_lcol;
    logic next_lcrs;
    logic next_lfull;

    always_comb begin
        next_lcol = m_mac ? col_in : (m_mii_phy & core_collision);
        next_lcrs = m_mac ? crs_in : (m_mii_phy & core_carrier);
        next_lfull = m_int ? 1'b0 : duplex_eff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            link_collision <= 1'b0;
            link_carrier <= 1'b0;
            link_full_duplex <= 1'b0;
        end else begin
            link_collision <= next_lcol;
            link_carrier <= next_lcrs;
            link_full_duplex <= next_lfull;
        end
    end

    // ------------------------------------------------------------
    // Link clock domain: collision and carrier pin drivers
    // ------------------------------------------------------------
    // Levels only; a pulse shorter than one link period may be lost
    logic [1:0] lrst_sync;
    logic [3:0] lk_meta;
    logic [3:0] lk_sync;
    logic drv_en;
    assign drv_en = m_mii_phy && !ctrl.isolate;

    always_ff @(posedge link_clk) begin
        lrst_sync <= {lrst_sync[0], srst};
        lk_meta <= {drv_en, core_collision, core_carrier, 1'b0};
        lk_sync <= lk_meta;
    end

    logic next_col_o;
    logic next_crs_o;
    logic next_oe;
    logic col_o;
    logic crs_o;
    logic lk_oe;

    always_comb begin
        next_oe = lk_sync[3];
        next_col_o = lk_sync[3] & lk_sync[2];
        next_crs_o = lk_sync[3] & lk_sync[1];
    end

    always_ff @(posedge link_clk) begin
        if (lrst_sync[1]) begin
            col_o <= 1'b0;
            crs_o <= 1'b0;
            lk_oe <= 1'b0;
        end else begin
            col_o <= next_col_o;
            crs_o <= next_crs_o;
            lk_oe <= next_oe;
        end
    end

    assign port_b_collision_pin_o = col_o;
    assign port_b_carrier_pin_o = crs_o;
    assign port_b_collision_pin_oe = lk_oe;
    assign port_b_carrier_pin_oe = lk_oe;

endmodule // pmx_pin_ctrl

// ---- bench/pmx_pin_ctrl_checker.sv ----
// Concurrent checks on the port B sideband pin control ports
module pmx_pin_ctrl_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic [pmx_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pmx_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pmx_pkg::DATA_W-1:0] reg_rdata,
    input wire logic eeprom_load,
    input wire logic core_collision,
    input wire logic core_carrier,
    input wire logic ref_clock_is_output,
    input wire logic port_b_ref_clock_pin_o,
    input wire logic port_b_ref_clock_pin_oe,
    input wire logic port_b_ref_clock_pin_ibuf_en,
    input wire logic port_b_ref_clock_pin_pd_en,
    input wire logic port_b_collision_pin_o,
    input wire logic port_b_collision_pin_oe,
    input wire logic port_b_carrier_pin_o,
    input wire logic port_b_carrier_pin_oe,
    input wire logic port_b_duplex_pin_pu_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link flops are known only three of their edges after reset
    logic [2:0] lk_up;
    always_ff @(posedge link_clk) lk_up <= srst ? 3'h0 : {lk_up[1:0], 1'b1};

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_status_read;
        reg_rd && reg_addr == pmx_pkg::ADDR_STATUS;
    endsequence
    // Six link edges cover the worst pipeline depth of three
    sequence s_col_high;
        (port_b_collision_pin_oe && core_collision)[*6];
    endsequence
    sequence s_crs_low;
        (port_b_carrier_pin_oe && !core_carrier)[*6];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_out_no_input: assert property (
        @(posedge clk) disable iff (srst) port_b_ref_clock_pin_oe
        |-> !port_b_ref_clock_pin_ibuf_en && !port_b_ref_clock_pin_pd_en)
        else $error("clock pin driven with input path on");
    a_input_pulls_down: assert property (
        @(posedge clk) disable iff (srst)
        port_b_ref_clock_pin_ibuf_en |-> port_b_ref_clock_pin_pd_en)
        else $error("clock input buffer on without pull-down");
    a_pullup_kept: assert property (
        @(posedge clk) disable iff (srst) port_b_duplex_pin_pu_en)
        else $error("duplex pin pull-up dropped");
    a_clock_runs: assert property (
        @(posedge clk) disable iff (srst) port_b_ref_clock_pin_oe[*5]
        |-> !($stable(port_b_ref_clock_pin_o)
        && port_b_ref_clock_pin_o == $past(port_b_ref_clock_pin_o, 2)))
        else $error("driven reference clock stalled");
    a_mac_no_drive: assert property (
        @(posedge clk) disable iff (srst) s_status_read ##1
        reg_rdata[2:0] inside {3'h0, 3'h7} |-> !$past(ref_clock_is_output))
        else $error("clock driven in MAC or internal mode");
    a_phy_drives: assert property (
        @(posedge clk) disable iff (srst) s_status_read ##1
        reg_rdata[2:0] inside {[3'h1:3'h3]} |-> $past(ref_clock_is_output))
        else $error("clock not driven in MII PHY mode");
    a_isolate_stops: assert property (
        @(posedge clk) disable iff (srst) reg_wr && !eeprom_load
        && reg_addr == pmx_pkg::ADDR_BASIC_CONTROL && reg_wdata[0]
        |-> ##[1:3] !port_b_ref_clock_pin_oe)
        else $error("isolate left clock driver on");
    a_col_follows: assert property (
        @(posedge link_clk) disable iff (srst || !lk_up[2])
        s_col_high |-> port_b_collision_pin_o)
        else $error("collision pin not following core");
    a_crs_follows: assert property (
        @(posedge link_clk) disable iff (srst || !lk_up[2])
        s_crs_low |-> !port_b_carrier_pin_o)
        else $error("carrier pin not following core");
    a_sideband_pair: assert property (
        @(posedge link_clk) disable iff (srst || !lk_up[2])
        port_b_collision_pin_oe == port_b_carrier_pin_oe)
        else $error("collision and carrier drivers disagree");
endmodule // pmx_pin_ctrl_checker

bind pmx_pin_ctrl pmx_pin_ctrl_checker u_checker (.*);

// ---- bench/pmx_far_end.sv ----
// Far-end MAC or PHY model on the port B sideband pins
module pmx_far_end (
    output logic link_clk,
    input wire logic phy_role,
    input wire logic col_val,
    input wire logic crs_val,
    input wire logic dup_val,
    input wire logic ref_o,
    input wire logic ref_oe,
    input wire logic col_o,
    input wire logic col_oe,
    input wire logic crs_o,
    input wire logic crs_oe,
    output logic ref_wire,
    output logic col_wire,
    output logic crs_wire,
    output logic dup_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    // far clock source
    // Free running, as a PHY transmit clock is
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // clock pin, pulled down; a fight shows as unknown
    assign ref_wire = ref_oe ? (phy_role ? 1'bx : ref_o)
        : (phy_role ? link_clk : 1'b0);
    assign col_wire = col_oe ? (phy_role ? 1'bx : col_o)
        : (phy_role ? col_val : 1'b1);
    assign crs_wire = crs_oe ? (phy_role ? 1'bx : crs_o)
        : (phy_role ? crs_val : 1'b0);
    // Duplex level strapped by the board
    assign dup_wire = dup_val;
endmodule // pmx_far_end

// ---- bench/pmx_pin_ctrl_test.sv ----
// Self-checking bench for the port B sideband pin control block
module pmx_pin_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;

    // Mode, polarity, duplex pin; then clock out, 16 mA, full, toggles
    typedef struct {int m, p, dv, out, d16, full, tog;} pmx_row_s;
    logic clk, srst, link_clk, reg_wr, reg_rd, eeprom_load;
    logic [pmx_pkg::ADDR_W-1:0] reg_addr;
    logic [pmx_pkg::DATA_W-1:0] reg_wdata, reg_rdata, v;
    logic [2:0] port_b_mode_strap, eeprom_mode;
    logic external_reset_pin_n, port_b_duplex_polarity_strap;
    logic eeprom_polarity, core_collision, core_carrier, link_collision;
    logic link_carrier, link_full_duplex, ref_clock_is_output;
    logic port_b_ref_clock_pin_i, port_b_ref_clock_pin_o;
    logic port_b_ref_clock_pin_oe, port_b_ref_clock_pin_drive_16ma;
    logic port_b_ref_clock_pin_ibuf_en, port_b_ref_clock_pin_pd_en;
    logic port_b_collision_pin_i, port_b_collision_pin_o;
    logic port_b_collision_pin_oe, port_b_carrier_pin_i;
    logic port_b_carrier_pin_o, port_b_carrier_pin_oe, port_b_duplex_pin_i;
    logic port_b_duplex_pin_pu_en, phy_role, col_val, crs_val, dup_val;
    logic prev;
    int n_fail, tests_run, tog;
    int cw [4] = '{2, 6, 1, 0};
    int ce [4] = '{8, 12, 0, 3};
    pmx_row_s rows [8] = '{
        '{0, 1, 1, 0, 0, 1, 10}, '{1, 0, 1, 1, 0, 0, 10},
        '{2, 1, 0, 1, 0, 0, 10}, '{3, 0, 0, 1, 1, 1, 10},
        '{4, 1, 1, 1, 0, 1, 20}, '{5, 0, 1, 1, 1, 0, 20},
        '{6, 1, 1, 0, 0, 1, 20}, '{7, 0, 0, 0, 0, 0, 10}};

    pmx_pin_ctrl dut (.*);
    pmx_far_end far (.link_clk(link_clk), .phy_role(phy_role),
        .col_val(col_val), .crs_val(crs_val), .dup_val(dup_val),
        .ref_o(port_b_ref_clock_pin_o), .ref_oe(port_b_ref_clock_pin_oe),
        .col_o(port_b_collision_pin_o), .col_oe(port_b_collision_pin_oe),
        .crs_o(port_b_carrier_pin_o), .crs_oe(port_b_carrier_pin_oe),
        .ref_wire(port_b_ref_clock_pin_i), .col_wire(port_b_collision_pin_i),
        .crs_wire(port_b_carrier_pin_i), .dup_wire(port_b_duplex_pin_i));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic st(input logic [31:0] mask, input logic [31:0] e);
        rd(pmx_pkg::ADDR_STATUS, v);
        chk("status", e, v & mask);
    endtask
    // Duplex pin settles through its synchroniser before the load
    task automatic load(input int m, input int p, input int dv);
        @(posedge clk);
        dup_val <= 1'(dv);
        repeat (4) @(posedge clk);
        eeprom_load <= 1'b1;
        eeprom_mode <= 3'(m);
        eeprom_polarity <= 1'(p);
        @(posedge clk);
        eeprom_load <= 1'b0;
        tick(30);
    endtask
    task automatic results;
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is about 720 cycles; the 20,000-cycle limit allows over 25 times that
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        n_fail = 0;
        tests_run = 0;
        srst = 1'b1;
        {reg_wr, reg_rd, eeprom_load, core_collision, core_carrier} = '0;
        {phy_role, col_val, crs_val, eeprom_polarity} = '0;
        {reg_addr, reg_wdata, eeprom_mode} = '0;
        {dup_val, external_reset_pin_n, port_b_duplex_polarity_strap} = '1;
        port_b_mode_strap = 3'h6;
        tick(2);
        chk("rst_oe", 0, port_b_ref_clock_pin_oe);
        chk("rst_pd", 1, port_b_ref_clock_pin_pd_en);
        @(posedge clk);
        srst <= 1'b0;
        tick(3);
        st(32'hC7, 32'hC6);
        foreach (rows[i]) begin
            load(rows[i].m, rows[i].p, rows[i].dv);
            st(32'hC7, 32'h80 | rows[i].p << 6 | rows[i].m);
            chk("ref_out", rows[i].out, ref_clock_is_output);
            chk("oe", rows[i].out, port_b_ref_clock_pin_oe);
            chk("d16", rows[i].d16, port_b_ref_clock_pin_drive_16ma);
            chk("full", rows[i].full, link_full_duplex);
            chk("col_oe", rows[i].m inside {[1:3]},
                port_b_collision_pin_oe);
            chk("crs_oe", rows[i].m inside {[1:3]},
                port_b_carrier_pin_oe);
            if (rows[i].m != 7) begin
                chk("pd", !rows[i].out, port_b_ref_clock_pin_pd_en);
                chk("ibuf", !rows[i].out, port_b_ref_clock_pin_ibuf_en);
            end
            tog = 0;
            prev = port_b_ref_clock_pin_o;
            repeat (20) begin
                tick(1);
                tog += int'(port_b_ref_clock_pin_o !== prev);
                prev = port_b_ref_clock_pin_o;
            end
            chk("toggles", rows[i].tog, tog);
        end
        // MAC mode: far end drives the sideband pins
        load(0, 1, 1);
        phy_role = 1'b1;
        col_val = 1'b1;
        crs_val = 1'b1;
        tick(10);
        chk("mac_col", 1, link_collision);
        chk("mac_crs", 1, link_carrier);
        st(32'h30, 32'h30);
        @(posedge clk);
        dup_val <= 1'b0;
        tick(10);
        chk("live_dup", 0, link_full_duplex);
        wr(pmx_pkg::ADDR_BASIC_CONTROL, 32'h0000_0018);
        tick(10);
        chk("manual_dup", 1, link_full_duplex);
        phy_role = 1'b0;
        // MII PHY: pin changes after capture must not move duplex
        load(1, 1, 1);
        @(posedge clk);
        core_collision <= 1'b1;
        core_carrier <= 1'b1;
        dup_val <= 1'b0;
        tick(30);
        chk("phy_col", 1, port_b_collision_pin_i);
        chk("phy_crs", 1, port_b_carrier_pin_i);
        chk("phy_dup", 1, link_full_duplex);
        wr(pmx_pkg::ADDR_BASIC_CONTROL, 32'h0000_0011);
        tick(30);
        chk("iso_col_oe", 0, port_b_collision_pin_oe);
        chk("iso_crs", 0, port_b_carrier_pin_i);
        chk("iso_clk_oe", 0, port_b_ref_clock_pin_oe);
        // RMII, clock input: direction, strength, isolate by software
        load(6, 1, 1);
        foreach (cw[i]) begin
            wr(pmx_pkg::ADDR_BASIC_CONTROL, 32'(cw[i]));
            tick(4);
            chk("sw_pins", ce[i], {port_b_ref_clock_pin_oe,
                port_b_ref_clock_pin_drive_16ma, port_b_ref_clock_pin_pd_en,
                port_b_ref_clock_pin_ibuf_en});
        end
        // Straps taken again when the reset pin lets go
        @(posedge clk);
        port_b_mode_strap <= 3'h5;
        port_b_duplex_polarity_strap <= 1'b0;
        external_reset_pin_n <= 1'b0;
        tick(5);
        @(posedge clk);
        external_reset_pin_n <= 1'b1;
        tick(10);
        st(32'hC7, 32'h85);
        chk("cap_d16", 1, port_b_ref_clock_pin_drive_16ma);
        rd(4'h8, v);
        chk("unmapped", 0, v);
        results();
    end
endmodule // pmx_pin_ctrl_test
